/* File: rrbsc_cfg.svh */
// Register map, field positions and reset values of the receive serializer control block.
// Assumes inclusion by bare name from every file that decodes the register map.
`ifndef RRBSC_CFG_SVH
`define RRBSC_CFG_SVH

// ----------------------------------------------------------------------
// Register addresses on the serial host port
// ----------------------------------------------------------------------
`define RRBSC_ADR_CONFIG   6'h05
`define RRBSC_ADR_SERCTL   6'h06
`define RRBSC_ADR_EVEN     6'h07
`define RRBSC_ADR_STAT     6'h08
`define RRBSC_ADR_DATA_A   6'h09
`define RRBSC_ADR_DATA_B   6'h0B

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RRBSC_RST_CONFIG   8'h01
`define RRBSC_RST_SERCTL   8'h03
`define RRBSC_RST_EVEN     8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RRBSC_SERDES_EN    3
`define RRBSC_EOF_LEN_HI   2
`define RRBSC_EOF_LEN_LO   0
`define RRBSC_SPI_WR_BIT   7
`define RRBSC_SPI_ADR_HI   5
// Per-channel nibble: channel A low, channel B high
`define RRBSC_FLD_FULL     2'h0
`define RRBSC_FLD_EOF      2'h1
`define RRBSC_FLD_OVF      2'h2
`define RRBSC_FLD_UNF      2'h3
// Pin drive selections
`define RRBSC_IRQ_SRC      2'h3
`define RRBSC_IRQ_DRAIN    2'h2
`define RRBSC_IRQ_CMOS     2'h1
`define RRBSC_IRQ_CMOS_INV 2'h0

// ----------------------------------------------------------------------
// Sizes and counts
// ----------------------------------------------------------------------
`define RRBSC_LAST_BIT     3'h7
`define RRBSC_FIFO_DEPTH   16

`endif

/* File: rrbsc_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and the active-low asynchronous reset of the block.
`timescale 1ns/1ps
module rrbsc_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0]                  wp;
		logic [AW:0]                  rp;
		logic [DEPTH-1:0][WIDTH-1:0]  mem;
	} rrbsc_fifo_st_t;

	rrbsc_fifo_st_t st_reg;
	rrbsc_fifo_st_t st_next;

	// ----------------------------------------------------------------------
	// Flags from pointers; extra bit tells full from empty
	// ----------------------------------------------------------------------
	assign out_valid = (st_reg.wp != st_reg.rp);
	assign in_ready  = (st_reg.wp[AW-1:0] != st_reg.rp[AW-1:0]) || (st_reg.wp[AW] == st_reg.rp[AW]);
	assign out_data  = st_reg.mem[st_reg.rp[AW-1:0]];

	// Push and pop may happen together
	always_comb begin
		st_next = st_reg;
		if (in_valid && in_ready) begin
			st_next.mem[st_reg.wp[AW-1:0]] = in_data;
			st_next.wp = st_reg.wp + 1'b1;
		end
		if (out_valid && out_ready) begin
			st_next.rp = st_reg.rp + 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule

/* File: rrbsc_host_model.sv */
// Host microcontroller model: drives the serial register port, mode 0, MSB first.
// Assumes the bench calls its tasks and that clk is the block clock.
`timescale 1ns/1ps
`include "rrbsc_cfg.svh"
module rrbsc_host_model (
	input  wire logic clk,
	output logic      spi_sclk,
	output logic      spi_cs_n,
	output logic      spi_mosi,
	input  wire logic spi_miso
);
	// Clocks per serial clock phase; the bench raises it to act slowly
	int half = 4;

	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ----------------------------------------------------------------------
	// One frame: command byte, then data byte
	// ----------------------------------------------------------------------
	task automatic frame(input logic [7:0] cmd, input logic [7:0] wdat, output logic [7:0] rdat);
		logic [15:0] sh;
		sh = {cmd, wdat};
		rdat = 8'h00;
		if (cmd == {2'b10, `RRBSC_ADR_SERCTL})
			sh[7:4] = 4'h0;
		@(posedge clk);
		spi_cs_n <= 1'b0;
		idle(4);
		for (int i = 15; i >= 0; i--) begin
			spi_mosi <= sh[i];
			idle(half);
			spi_sclk <= 1'b1;
			// Miso settled since the previous fall, so take it at the rise
			if (i < 8)
				rdat = {rdat[6:0], spi_miso};
			idle(half);
			spi_sclk <= 1'b0;
		end
		idle(half);
		spi_cs_n <= 1'b1;
		// Released line shows no stale value
		spi_mosi <= ~spi_mosi;
		idle(6);
	endtask

	// Select held without clocks: stalls the block's buffer drain
	task automatic hold(input int n);
		@(posedge clk);
		spi_cs_n <= 1'b0;
		idle(n);
		spi_cs_n <= 1'b1;
		idle(6);
	endtask
endmodule

/* File: rrbsc_pkg.sv */
// Types shared by the receive serializer control block and its buffer.
// Assumes the including design reads constants from rrbsc_cfg.svh.
package rrbsc_pkg;

	// ----------------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic       chan;
		logic       all_valid;
		logic [7:0] data;
	} rrbsc_rx_word_t;

	typedef enum logic [1:0] {RRBSC_SP_IDLE, RRBSC_SP_CMD, RRBSC_SP_DATA} rrbsc_spi_phase_t;

	typedef struct packed {
		logic [7:0] shreg;
		logic [2:0] nbits;
		logic       seen;
		logic [3:0] gap;
	} rrbsc_asm_t;

	typedef struct packed {
		logic [7:0] data;
		logic       full;
		logic       all_valid;
	} rrbsc_dreg_t;

	// ----------------------------------------------------------------------
	// Whole state of the top module
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic                        sclk_s1, sclk_s2, sclk_d;
		logic                        cs_s1, cs_s2;
		logic                        mosi_s1, mosi_s2;
		rrbsc_spi_phase_t            phase;
		logic [2:0]                  bitcnt;
		logic [7:0]                  rx_sh;
		logic [7:0]                  tx_sh;
		logic                        is_wr;
		logic [5:0]                  addr;
		logic [7:0]                  config_reg;
		logic [7:0]                  serctl_reg;
		logic [7:0]                  even_reg;
		logic [7:0]                  pend;
		rrbsc_asm_t [1:0]            asmb;
		rrbsc_dreg_t [1:0]           dreg;
		logic [1:0]                  slot_vld;
		rrbsc_rx_word_t [1:0]        slot;
		logic                        miso;
		logic                        miso_oe;
		logic                        irq_o;
		logic                        irq_oe;
		logic                        sbit;
		logic                        sbit_vld;
	} rrbsc_state_t;

endpackage

/* File: rrbsc_top.sv */
// Receive serializer control: host serial port, per-channel byte assembly with
// end-of-frame detection, receive data registers, event flags and interrupt pin.
// Assumes correlator outputs and bit strobe come from logic on clk; host port pins are async.
//
// Notes on behaviour
// - Control bit 3 selects byte or bit-serial
// - Bits 2:0 set end-of-frame gap length
// - Gap counts only in receive, after data
// - End-of-frame when gap exceeds length
// - End-of-frame moves partial byte to register
// - Length zero: first invalid bit ends frame
// - Channel A data at 0x09, B at 0x0B
// - Reading empty data register flags underflow
// - Loading unread data register flags overflow
// - End-of-frame raises enabled interrupt request
// - Every register load flags full
// - Status shows combined flow flag, read clears
// - Two-bit select sets interrupt pin drive
`timescale 1ns/1ps
`include "rrbsc_cfg.svh"
module rrbsc_top #(
	parameter int FIFO_DEPTH = `RRBSC_FIFO_DEPTH
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       spi_sclk,
	input  wire logic       spi_cs_n,
	input  wire logic       spi_mosi,
	output logic            spi_miso,
	output logic            spi_miso_oe,
	input  wire logic       rx_mode,
	input  wire logic       bit_strobe,
	input  wire logic [1:0] corr_valid,
	input  wire logic [1:0] corr_bit,
	output logic            serial_bit_pin,
	output logic            serial_bit_valid_pin,
	output logic            irq_o,
	output logic            irq_oe
);
	rrbsc_pkg::rrbsc_state_t   st_reg;
	rrbsc_pkg::rrbsc_state_t   st_next;
	rrbsc_pkg::rrbsc_rx_word_t fifo_in;
	rrbsc_pkg::rrbsc_rx_word_t fifo_out;
	logic                      fifo_in_vld;
	logic                      fifo_in_rdy;
	logic                      fifo_out_vld;
	logic                      fifo_out_rdy;
	logic                      take;
	logic                      pop;
	logic [2:0]                eof_len;

	// Pending bit index inside the per-channel nibble layout
	function automatic logic [2:0] fidx(input logic ch, input logic [1:0] fld);
		return {ch, fld};
	endfunction

	// ----------------------------------------------------------------------
	// Buffer between assembly and data registers
	// ----------------------------------------------------------------------
	assign eof_len      = st_reg.serctl_reg[`RRBSC_EOF_LEN_HI:`RRBSC_EOF_LEN_LO];
	// Strobes are skipped while a slot waits; a full FIFO stalls assembly
	assign take         = bit_strobe && rx_mode && st_reg.serctl_reg[`RRBSC_SERDES_EN]
	                      && (st_reg.slot_vld == 2'h0);
	assign fifo_in_vld  = |st_reg.slot_vld;
	assign fifo_in      = st_reg.slot_vld[0] ? st_reg.slot[0] : st_reg.slot[1];
	// Drain only with the host port idle so a read never races a load
	assign fifo_out_rdy = st_reg.cs_s2;
	assign pop          = fifo_out_vld && fifo_out_rdy;

	rrbsc_fifo #(
		.WIDTH ($bits(rrbsc_pkg::rrbsc_rx_word_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (fifo_in_vld),
		.in_ready  (fifo_in_rdy),
		.in_data   (fifo_in),
		.out_valid (fifo_out_vld),
		.out_ready (fifo_out_rdy),
		.out_data  (fifo_out)
	);

	// ----------------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------------
	always_comb begin
		logic [7:0]              rx_n;
		logic [7:0]              rdata;
		logic [7:0]              set_v;
		logic [7:0]              clr_v;
		logic                    rise;
		logic                    fall;
		logic [3:0]              gap_n;
		rrbsc_pkg::rrbsc_asm_t   a;
		rx_n    = 8'h00;
		rdata   = 8'h00;
		set_v   = 8'h00;
		clr_v   = 8'h00;
		gap_n   = 4'h0;
		a       = '0;
		st_next = st_reg;
		// Two-flop synchronisers; stage two is read, and for sclk also its one-cycle delay sclk_d
		st_next.sclk_s1 = spi_sclk;
		st_next.sclk_s2 = st_reg.sclk_s1;
		st_next.sclk_d  = st_reg.sclk_s2;
		st_next.cs_s1   = spi_cs_n;
		st_next.cs_s2   = st_reg.cs_s1;
		st_next.mosi_s1 = spi_mosi;
		st_next.mosi_s2 = st_reg.mosi_s1;
		rise = st_reg.sclk_s2 && !st_reg.sclk_d;
		fall = !st_reg.sclk_s2 && st_reg.sclk_d;

		// Bit-serial path mirrors channel A on the pins
		if (st_reg.serctl_reg[`RRBSC_SERDES_EN]) begin
			st_next.sbit     = 1'b0;
			st_next.sbit_vld = 1'b0;
		end else if (bit_strobe) begin
			st_next.sbit     = corr_bit[0];
			st_next.sbit_vld = corr_valid[0] && rx_mode;
		end

		// Byte assembly and end-of-frame per channel
		for (int c = 0; c < 2; c++) begin
			a = st_reg.asmb[c];
			if (!rx_mode || !st_reg.serctl_reg[`RRBSC_SERDES_EN]) begin
				a = '0;
			end else if (take && corr_valid[c]) begin
				a.shreg = {st_reg.asmb[c].shreg[6:0], corr_bit[c]};
				a.seen  = 1'b1;
				a.gap   = 4'h0;
				if (st_reg.asmb[c].nbits == `RRBSC_LAST_BIT) begin
					st_next.slot_vld[c] = 1'b1;
					st_next.slot[c]     = '{chan: c[0], all_valid: 1'b1, data: a.shreg};
					a                   = '{shreg: 8'h00, nbits: 3'h0, seen: 1'b1, gap: 4'h0};
				end else begin
					a.nbits = 3'(st_reg.asmb[c].nbits + 3'h1);
				end
			end else if (take && st_reg.asmb[c].seen) begin
				gap_n = 4'(st_reg.asmb[c].gap + 4'h1);
				if (gap_n > {1'b0, eof_len}) begin
					set_v[fidx(c[0], `RRBSC_FLD_EOF)] = 1'b1;
					if (st_reg.asmb[c].nbits != 3'h0) begin
						st_next.slot_vld[c] = 1'b1;
						st_next.slot[c]     = '{chan: c[0], all_valid: 1'b0,
						                        data: st_reg.asmb[c].shreg};
					end
					a = '0;
				end else begin
					a.gap = gap_n;
				end
			end
			st_next.asmb[c] = a;
		end

		// Slot handed to the FIFO, channel A first
		if (fifo_in_vld && fifo_in_rdy) begin
			if (st_reg.slot_vld[0]) begin
				st_next.slot_vld[0] = 1'b0;
			end else begin
				st_next.slot_vld[1] = 1'b0;
			end
		end

		// Load of a data register from the FIFO
		if (pop) begin
			if (st_reg.dreg[fifo_out.chan].full) begin
				set_v[fidx(fifo_out.chan, `RRBSC_FLD_OVF)] = 1'b1;
			end
			set_v[fidx(fifo_out.chan, `RRBSC_FLD_FULL)] = 1'b1;
			st_next.dreg[fifo_out.chan] = '{data: fifo_out.data, full: 1'b1,
			                                all_valid: fifo_out.all_valid};
		end

		// Host serial port, mode 0, command byte then data byte
		if (st_reg.cs_s2) begin
			st_next.phase  = rrbsc_pkg::RRBSC_SP_IDLE;
			st_next.bitcnt = 3'h0;
			st_next.miso   = 1'b0;
		end else begin
			unique case (st_reg.phase)
				rrbsc_pkg::RRBSC_SP_IDLE: begin
					st_next.phase = rrbsc_pkg::RRBSC_SP_CMD;
					st_next.tx_sh = 8'h00;
				end
				rrbsc_pkg::RRBSC_SP_CMD, rrbsc_pkg::RRBSC_SP_DATA: begin
					if (rise) begin
						rx_n           = {st_reg.rx_sh[6:0], st_reg.mosi_s2};
						st_next.rx_sh  = rx_n;
						st_next.bitcnt = 3'(st_reg.bitcnt + 3'h1);
					end
					if (rise && st_reg.bitcnt == `RRBSC_LAST_BIT
					    && st_reg.phase == rrbsc_pkg::RRBSC_SP_CMD) begin
						st_next.phase = rrbsc_pkg::RRBSC_SP_DATA;
						st_next.is_wr = rx_n[`RRBSC_SPI_WR_BIT];
						st_next.addr  = rx_n[`RRBSC_SPI_ADR_HI:0];
						if (!rx_n[`RRBSC_SPI_WR_BIT]) begin
							// Read side effects happen when the address is known
							case (rx_n[`RRBSC_SPI_ADR_HI:0])
								`RRBSC_ADR_CONFIG: rdata = st_reg.config_reg;
								`RRBSC_ADR_SERCTL: rdata = st_reg.serctl_reg;
								`RRBSC_ADR_EVEN:   rdata = st_reg.even_reg;
								`RRBSC_ADR_STAT: begin
									for (int c = 0; c < 2; c++) begin
										rdata[fidx(c[0], `RRBSC_FLD_FULL)] =
											st_reg.pend[fidx(c[0], `RRBSC_FLD_FULL)];
										rdata[fidx(c[0], `RRBSC_FLD_EOF)] =
											st_reg.pend[fidx(c[0], `RRBSC_FLD_EOF)];
										rdata[fidx(c[0], `RRBSC_FLD_OVF)] =
											st_reg.pend[fidx(c[0], `RRBSC_FLD_OVF)]
											| st_reg.pend[fidx(c[0], `RRBSC_FLD_UNF)];
										rdata[fidx(c[0], `RRBSC_FLD_UNF)] =
											st_reg.dreg[c].all_valid;
									end
									clr_v = 8'hFF;
								end
								`RRBSC_ADR_DATA_A, `RRBSC_ADR_DATA_B: begin
									rdata = st_reg.dreg[rx_n[1]].data;
									if (st_reg.dreg[rx_n[1]].full) begin
										st_next.dreg[rx_n[1]].full = 1'b0;
									end else begin
										set_v[fidx(rx_n[1], `RRBSC_FLD_UNF)] = 1'b1;
									end
								end
								default: rdata = 8'h00;
							endcase
							st_next.tx_sh = rdata;
						end
					end else if (rise && st_reg.bitcnt == `RRBSC_LAST_BIT && st_reg.is_wr) begin
						// Reserved bits are stored as written
						unique case (st_reg.addr)
							`RRBSC_ADR_CONFIG: st_next.config_reg = rx_n;
							`RRBSC_ADR_SERCTL: st_next.serctl_reg = rx_n;
							`RRBSC_ADR_EVEN:   st_next.even_reg   = rx_n;
							default: ;
						endcase
					end
					if (fall) begin
						st_next.miso  = st_reg.tx_sh[7];
						st_next.tx_sh = {st_reg.tx_sh[6:0], 1'b0};
					end
				end
			endcase
		end
		st_next.miso_oe = !st_reg.cs_s2;
		// Set wins over a clear in the same cycle
		st_next.pend = (st_reg.pend & ~clr_v) | set_v;
		// Interrupt pin drive, one cycle behind the flags
		unique case (st_reg.config_reg[1:0])
			`RRBSC_IRQ_SRC: begin
				st_next.irq_o  = 1'b1;
				st_next.irq_oe = |(st_reg.pend & st_reg.even_reg);
			end
			`RRBSC_IRQ_DRAIN: begin
				st_next.irq_o  = 1'b0;
				st_next.irq_oe = |(st_reg.pend & st_reg.even_reg);
			end
			`RRBSC_IRQ_CMOS: begin
				st_next.irq_o  = |(st_reg.pend & st_reg.even_reg);
				st_next.irq_oe = 1'b1;
			end
			`RRBSC_IRQ_CMOS_INV: begin
				st_next.irq_o  = ~|(st_reg.pend & st_reg.even_reg);
				st_next.irq_oe = 1'b1;
			end
		endcase
	end

	// State register; port synchronisers reset to the idle levels
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg            <= '0;
			st_reg.cs_s1      <= 1'b1;
			st_reg.cs_s2      <= 1'b1;
			st_reg.config_reg <= `RRBSC_RST_CONFIG;
			st_reg.serctl_reg <= `RRBSC_RST_SERCTL;
			st_reg.even_reg   <= `RRBSC_RST_EVEN;
			st_reg.irq_oe     <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign spi_miso             = st_reg.miso;
	assign spi_miso_oe          = st_reg.miso_oe;
	assign serial_bit_pin       = st_reg.sbit;
	assign serial_bit_valid_pin = st_reg.sbit_vld;
	assign irq_o                = st_reg.irq_o;
	assign irq_oe               = st_reg.irq_oe;

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_gap_a;
		take && !corr_valid[0] && st_reg.asmb[0].seen;
	endsequence
	sequence s_load_busy_a;
		pop && !fifo_out.chan && st_reg.dreg[0].full;
	endsequence
	AST_BYTE_MODE_PINS: assert property (
		st_reg.serctl_reg[`RRBSC_SERDES_EN] |=> !serial_bit_valid_pin)
		else $error("bit-serial pins active in byte mode");
	AST_BIT_MODE_FOLLOW: assert property (
		bit_strobe && rx_mode && !st_reg.serctl_reg[`RRBSC_SERDES_EN]
		|=> serial_bit_valid_pin == $past(corr_valid[0]) && serial_bit_pin == $past(corr_bit[0]))
		else $error("bit-serial pins do not follow channel A");
	AST_NO_RX_NO_COUNT: assert property (
		!rx_mode |=> !st_reg.asmb[0].seen && st_reg.asmb[0].gap == 4'h0)
		else $error("gap counter active outside receive");
	AST_EOF_LEN_ZERO: assert property (
		s_gap_a and (eof_len == 3'h0) |=> st_reg.pend[0 + `RRBSC_FLD_EOF] && !st_reg.asmb[0].seen)
		else $error("length zero did not end frame on first invalid bit");
	AST_EOF_NOT_EARLY: assert property (
		s_gap_a and (4'(st_reg.asmb[0].gap + 4'h1) <= {1'b0, eof_len}) |=> st_reg.asmb[0].seen)
		else $error("frame ended before gap exceeded length");
	AST_EOF_PARTIAL: assert property (
		s_gap_a and (4'(st_reg.asmb[0].gap + 4'h1) > {1'b0, eof_len})
		and (st_reg.asmb[0].nbits != 3'h0) |=> st_reg.slot_vld[0] && !st_reg.slot[0].all_valid)
		else $error("partial byte not transferred at end of frame");
	AST_OVERFLOW: assert property (
		s_load_busy_a |=> st_reg.pend[0 + `RRBSC_FLD_OVF] && st_reg.pend[0 + `RRBSC_FLD_FULL])
		else $error("overflow not flagged on load of unread register");
	AST_UNDERFLOW: assert property (
		!st_reg.cs_s2 && st_reg.phase == rrbsc_pkg::RRBSC_SP_CMD && !st_reg.dreg[0].full
		&& st_reg.bitcnt == `RRBSC_LAST_BIT && st_reg.sclk_s2 && !st_reg.sclk_d
		&& {st_reg.rx_sh[6:0], st_reg.mosi_s2} == {2'b00, `RRBSC_ADR_DATA_A}
		|=> st_reg.pend[0 + `RRBSC_FLD_UNF])
		else $error("underflow not flagged on read of empty register");
	AST_IRQ_CMOS: assert property (
		st_reg.config_reg[1:0] == `RRBSC_IRQ_CMOS && $stable(st_reg.config_reg)
		|=> irq_o == |($past(st_reg.pend) & $past(st_reg.even_reg)) && irq_oe)
		else $error("push-pull interrupt level wrong");
	AST_IRQ_DRAIN: assert property (
		st_reg.config_reg[1:0] == `RRBSC_IRQ_DRAIN ##1 st_reg.config_reg[1:0] == `RRBSC_IRQ_DRAIN
		|-> !irq_o)
		else $error("open-drain interrupt drove high");
endmodule

/* File: tb.sv */
// Testbench: host frames and radio bit stimulus, checks of registers, flags and pins.
// Assumes the host model on the serial port and a 20 MHz block clock.
`timescale 1ns/1ps
`include "rrbsc_cfg.svh"
module tb;
	logic       clk, rst_n, rx_mode, bit_strobe;
	logic [1:0] corr_valid, corr_bit;
	logic       sclk, cs_n, mosi, miso, miso_oe;
	logic       sbit, sbit_vld, irq_o, irq_oe;
	int         bad_count = 0;
	int         n_tests = 0;

	rrbsc_top #(.FIFO_DEPTH(4)) rrbsc_top_i (.clk(clk), .rst_n(rst_n), .spi_sclk(sclk),
		.spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
		.rx_mode(rx_mode), .bit_strobe(bit_strobe), .corr_valid(corr_valid),
		.corr_bit(corr_bit), .serial_bit_pin(sbit), .serial_bit_valid_pin(sbit_vld),
		.irq_o(irq_o), .irq_oe(irq_oe));
	rrbsc_host_model rrbsc_host_model_i (.clk(clk), .spi_sclk(sclk), .spi_cs_n(cs_n),
		.spi_mosi(mosi), .spi_miso(miso));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ----------------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------------
	task automatic tally_and_finish;
		if (bad_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] r;
		rrbsc_host_model_i.frame({2'b10, a}, d, r);
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] r;
		rrbsc_host_model_i.frame({2'b00, a}, 8'h00, r);
		chk(r & m, e);
	endtask

	// One bit time; spacing well above the hand-off latency
	task automatic rbit(input logic va, input logic ba, input logic vb, input logic bb);
		@(posedge clk);
		bit_strobe <= 1'b1;
		corr_valid <= {vb, va};
		corr_bit   <= {bb, ba};
		@(posedge clk);
		bit_strobe <= 1'b0;
		idle(6);
	endtask

	task automatic rbyte(input logic [7:0] a, input logic [7:0] b, input logic vb);
		for (int i = 7; i >= 0; i--)
			rbit(1'b1, a[i], vb, b[i]);
	endtask

	// Every drive selection against the expected pin level and enable
	task automatic pin_loop(input logic any);
		logic [7:0] d;
		for (int s = 0; s < 4; s++) begin
			wr(`RRBSC_ADR_CONFIG, 8'(s));
			idle(3);
			case (s)
				0: d = {6'h00, ~any, 1'b1};
				1: d = {6'h00, any, 1'b1};
				2: d = {6'h00, 1'b0, any};
				default: d = {6'h00, 1'b1, any};
			endcase
			chk({6'h00, irq_o, irq_oe}, d);
		end
	endtask

	// Hang guard: the sequence needs well under 20000 clocks
	initial begin
		idle(60000);
		bad_count++;
		tally_and_finish();
	end

	// ----------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		rx_mode = 1'b1;
		bit_strobe = 1'b0;
		corr_valid = 2'h0;
		corr_bit = 2'h0;
		idle(8);
		rst_n <= 1'b1;
		idle(3);
		chk({6'h00, irq_o, irq_oe}, 8'h01);
		chk({7'h00, miso_oe}, 8'h00);
		rd(`RRBSC_ADR_SERCTL, 8'hFF, 8'h03);
		rd(`RRBSC_ADR_EVEN, 8'hFF, 8'h00);
		rd(`RRBSC_ADR_CONFIG, 8'hFF, 8'h01);
		wr(6'h0A, 8'h5A);
		rd(6'h0A, 8'hFF, 8'h00);
		wr(`RRBSC_ADR_STAT, 8'hFF);
		rd(`RRBSC_ADR_STAT, 8'hFF, 8'h00);
		// No frame end without data, nor while out of receive
		wr(`RRBSC_ADR_SERCTL, 8'h08);
		rbit(1'b0, 1'b0, 1'b0, 1'b0);
		rx_mode <= 1'b0;
		rbit(1'b1, 1'b1, 1'b1, 1'b1);
		rx_mode <= 1'b1;
		rbit(1'b0, 1'b0, 1'b0, 1'b0);
		rd(`RRBSC_ADR_STAT, 8'hFF, 8'h00);
		// Whole bytes on both channels
		wr(`RRBSC_ADR_EVEN, 8'h01);
		rbyte(8'hA5, 8'h3C, 1'b1);
		idle(4);
		chk({7'h00, irq_o}, 8'h01);
		rd(`RRBSC_ADR_STAT, 8'hFF, 8'h99);
		idle(3);
		chk({7'h00, irq_o}, 8'h00);
		rd(`RRBSC_ADR_DATA_A, 8'hFF, 8'hA5);
		rd(`RRBSC_ADR_DATA_B, 8'hFF, 8'h3C);
		// Empty register read returns the last byte and flags underflow
		wr(`RRBSC_ADR_EVEN, 8'h08);
		rd(`RRBSC_ADR_DATA_A, 8'hFF, 8'hA5);
		idle(3);
		chk({7'h00, irq_o}, 8'h01);
		rd(`RRBSC_ADR_STAT, 8'h77, 8'h04);
		// Length zero: first invalid bit closes a three-bit frame
		wr(`RRBSC_ADR_EVEN, 8'h02);
		rbit(1'b1, 1'b1, 1'b0, 1'b0);
		rbit(1'b1, 1'b0, 1'b0, 1'b0);
		rbit(1'b1, 1'b1, 1'b0, 1'b0);
		rbit(1'b0, 1'b0, 1'b0, 1'b0);
		idle(4);
		chk({7'h00, irq_o}, 8'h01);
		rd(`RRBSC_ADR_STAT, 8'h0F, 8'h03);
		idle(3);
		chk({7'h00, irq_o}, 8'h00);
		rd(`RRBSC_ADR_DATA_A, 8'hFF, 8'h05);
		// Length two: the third invalid bit closes the frame
		wr(`RRBSC_ADR_SERCTL, 8'h0A);
		rbit(1'b1, 1'b1, 1'b0, 1'b0);
		rbit(1'b1, 1'b1, 1'b0, 1'b0);
		rbit(1'b0, 1'b0, 1'b0, 1'b0);
		rbit(1'b0, 1'b0, 1'b0, 1'b0);
		rd(`RRBSC_ADR_STAT, 8'h0F, 8'h00);
		rbit(1'b0, 1'b0, 1'b0, 1'b0);
		rd(`RRBSC_ADR_STAT, 8'h0F, 8'h03);
		rd(`RRBSC_ADR_DATA_A, 8'hFF, 8'h03);
		// Buffer filled while the host stalls the drain; sixth byte refused
		wr(`RRBSC_ADR_EVEN, 8'h04);
		fork
			rrbsc_host_model_i.hold(450);
			for (int k = 1; k <= 6; k++)
				rbyte(8'(8'h11 * k), 8'h00, 1'b0);
			begin
				idle(100);
				chk({7'h00, miso_oe}, 8'h01);
			end
		join
		idle(30);
		chk({7'h00, irq_o}, 8'h01);
		rd(`RRBSC_ADR_STAT, 8'h0F, 8'h0D);
		rd(`RRBSC_ADR_DATA_A, 8'hFF, 8'h55);
		// Bit-serial pins follow channel A; silent in byte mode
		wr(`RRBSC_ADR_SERCTL, 8'h02);
		rbit(1'b1, 1'b1, 1'b0, 1'b0);
		chk({6'h00, sbit, sbit_vld}, 8'h03);
		rbit(1'b1, 1'b0, 1'b0, 1'b0);
		chk({6'h00, sbit, sbit_vld}, 8'h01);
		rbit(1'b0, 1'b1, 1'b0, 1'b0);
		chk({7'h00, sbit_vld}, 8'h00);
		wr(`RRBSC_ADR_SERCTL, 8'h0B);
		rbit(1'b1, 1'b1, 1'b0, 1'b0);
		chk({7'h00, sbit_vld}, 8'h00);
		// Pin drive with nothing pending, then with an enabled underflow
		wr(`RRBSC_ADR_EVEN, 8'h08);
		rd(`RRBSC_ADR_STAT, 8'hFF, 8'h88);
		pin_loop(1'b0);
		rd(`RRBSC_ADR_DATA_A, 8'hFF, 8'h55);
		pin_loop(1'b1);
		rrbsc_host_model_i.half = 10;
		rd(`RRBSC_ADR_CONFIG, 8'hFF, 8'h03);
		tally_and_finish();
	end
endmodule
